/* verilog/ascr_pkg.sv */
// Purpose: Constants for the converter configuration register bank.
// Assumes: Byte-wide configuration port with 12-bit addresses.
// Notes:   Multi-byte registers are little-endian across ascending addresses.
package ascr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned POS_W  = 24;
  localparam int unsigned FS_W   = 16;
  localparam int unsigned PE_W   = 4;
  // Lowest bit of the second and of the third byte of a multi-byte register.
  localparam int unsigned BYTE_1_LSB = 8;
  localparam int unsigned BYTE_2_LSB = 16;
  // Byte addresses of the register bytes.
  localparam logic [11:0] ADDR_POS_0 = 12'h02C;
  localparam logic [11:0] ADDR_POS_1 = 12'h02D;
  localparam logic [11:0] ADDR_POS_2 = 12'h02E;
  localparam logic [11:0] ADDR_FSA_0 = 12'h030;
  localparam logic [11:0] ADDR_FSA_1 = 12'h031;
  localparam logic [11:0] ADDR_FSB_0 = 12'h032;
  localparam logic [11:0] ADDR_FSB_1 = 12'h033;
  localparam logic [11:0] ADDR_BYP   = 12'h038;
  localparam logic [11:0] ADDR_TS    = 12'h03B;
  localparam logic [11:0] ADDR_PE    = 12'h048;
  // Reset values.
  localparam logic [15:0] FS_RESET   = 16'hA000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [7:0]  READ_ZERO  = 8'h00;
  // Field positions.
  localparam int unsigned BYP_BIT    = 0;
  localparam int unsigned TS_EN_BIT  = 0;
  localparam int unsigned TS_LV_BIT  = 1;
endpackage

/* verilog/ascr_regs.sv */
// Purpose: Configuration and status register bank of the data converter.
// Assumes: Port strobes are synchronous to clk_sys_in; one access per strobe.
// Notes:   Reserved bits of writable bytes hold their written value.
//
// How it works
// R01 - Read-only 24-bit capture location of the timing edge versus sampling clock.
// R02 - Software reads capture location, then picks its delay choice value.
// R03 - Input A full-scale word, 16-bit read/write, resets to 0xA000.
// R04 - Software keeps full-scale words between 0x2000 and 0xFFFF; lower accepted.
// R05 - Input B full-scale word, independent, same reset and mapping as A.
// R06 - Reference bypass bit 0 selects analog core supply as reference; resets zero.
// R07 - Timestamp control bit 0 enables timestamp receiver; resets to disabled.
// R08 - Timestamp control bit 1 selects low-swing signalling mode; resets zero.
// R09 - Four-bit pre-emphasis in bits 3..0 drives all sixteen lanes; resets zero.
// R10 - Status magnify control changes resolution of reported capture location.
// R11 - Writes to the capture location are ignored.
`timescale 1ns/1ns
module ascr_regs
  import ascr_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk_sys_in,
  input  wire logic               srst_in,
  // Configuration port.
  input  wire logic [ADDR_W-1:0]  cfg_addr_in,
  input  wire logic [DATA_W-1:0]  cfg_wdata_in,
  input  wire logic               cfg_wr_in,
  input  wire logic               cfg_rd_in,
  output logic      [DATA_W-1:0]  cfg_rdata_out,
  // Capture location from the timing-edge detector.
  input  wire logic [POS_W-1:0]   sysref_capture_location_in,
  input  wire logic               sysref_status_magnify_in,
  // Controls to the analog and serial sections.
  output logic      [FS_W-1:0]    input_a_fullscale_word_out,
  output logic      [FS_W-1:0]    input_b_fullscale_word_out,
  output logic                    reference_bypass_bit_out,
  output logic                    timestamp_receiver_enable_out,
  output logic                    timestamp_low_swing_mode_out,
  output logic      [PE_W-1:0]    lane_pre_emphasis_out
);

  logic [FS_W-1:0]   fsa_q;
  logic [FS_W-1:0]   fsb_q;
  logic [DATA_W-1:0] byp_q;
  logic [DATA_W-1:0] ts_q;
  logic [DATA_W-1:0] pe_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rd_mux;

  // Write strobes per byte; capture-location addresses have none.
  wire wr_fsa0 = cfg_wr_in && (cfg_addr_in == ADDR_FSA_0); // R11
  wire wr_fsa1 = cfg_wr_in && (cfg_addr_in == ADDR_FSA_1);
  wire wr_fsb0 = cfg_wr_in && (cfg_addr_in == ADDR_FSB_0);
  wire wr_fsb1 = cfg_wr_in && (cfg_addr_in == ADDR_FSB_1);
  wire wr_byp  = cfg_wr_in && (cfg_addr_in == ADDR_BYP);
  wire wr_ts   = cfg_wr_in && (cfg_addr_in == ADDR_TS);
  wire wr_pe   = cfg_wr_in && (cfg_addr_in == ADDR_PE);

  // Full-scale words accept any code, including those below the advised minimum.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      fsa_q <= FS_RESET; // R03
      fsb_q <= FS_RESET; // R05
    end
    else
    begin
      if (wr_fsa0) fsa_q[BYTE_1_LSB-1:0]    <= cfg_wdata_in; // R03
      if (wr_fsa1) fsa_q[FS_W-1:BYTE_1_LSB] <= cfg_wdata_in; // R03
      if (wr_fsb0) fsb_q[BYTE_1_LSB-1:0]    <= cfg_wdata_in; // R05
      if (wr_fsb1) fsb_q[FS_W-1:BYTE_1_LSB] <= cfg_wdata_in; // R05
    end
  end

  // Single-byte control registers.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      byp_q <= BYTE_RESET; // R06
      ts_q  <= BYTE_RESET; // R07 R08
      pe_q  <= BYTE_RESET; // R09
    end
    else
    begin
      if (wr_byp) byp_q <= cfg_wdata_in; // R06
      if (wr_ts)  ts_q  <= cfg_wdata_in; // R07 R08
      if (wr_pe)  pe_q  <= cfg_wdata_in; // R09
    end
  end

  // Read selection; the live capture location reads straight through.
  assign rd_mux =
    (cfg_addr_in == ADDR_POS_0) ? sysref_capture_location_in[BYTE_1_LSB-1:0] : // R01 R10
    (cfg_addr_in == ADDR_POS_1) ? sysref_capture_location_in[BYTE_2_LSB-1:BYTE_1_LSB] : // R01
    (cfg_addr_in == ADDR_POS_2) ? sysref_capture_location_in[POS_W-1:BYTE_2_LSB] : // R01
    (cfg_addr_in == ADDR_FSA_0) ? fsa_q[BYTE_1_LSB-1:0] :
    (cfg_addr_in == ADDR_FSA_1) ? fsa_q[FS_W-1:BYTE_1_LSB] :
    (cfg_addr_in == ADDR_FSB_0) ? fsb_q[BYTE_1_LSB-1:0] :
    (cfg_addr_in == ADDR_FSB_1) ? fsb_q[FS_W-1:BYTE_1_LSB] :
    (cfg_addr_in == ADDR_BYP)   ? byp_q :
    (cfg_addr_in == ADDR_TS)    ? ts_q :
    (cfg_addr_in == ADDR_PE)    ? pe_q :
    READ_ZERO;

  // Read data is registered on the read strobe and held until the next one.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      rdata_q <= READ_ZERO;
    else if (cfg_rd_in)
      rdata_q <= rd_mux;
  end

  assign cfg_rdata_out                 = rdata_q;
  assign input_a_fullscale_word_out    = fsa_q;
  assign input_b_fullscale_word_out    = fsb_q;
  assign reference_bypass_bit_out      = byp_q[BYP_BIT];  // R06
  assign timestamp_receiver_enable_out = ts_q[TS_EN_BIT]; // R07
  assign timestamp_low_swing_mode_out  = ts_q[TS_LV_BIT]; // R08
  assign lane_pre_emphasis_out         = pe_q[PE_W-1:0];  // R09

  // A read of the high capture byte returns the high byte of the live location.
  pos_read_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R01
    (cfg_rd_in && cfg_addr_in == ADDR_POS_2) |=>
      cfg_rdata_out == $past(sysref_capture_location_in[POS_W-1:BYTE_2_LSB]))
    else $error("Capture location high byte read wrong.");

  // The middle capture byte reads through in the same way.
  pos_mid_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R01
    (cfg_rd_in && cfg_addr_in == ADDR_POS_1) |=>
      cfg_rdata_out == $past(sysref_capture_location_in[BYTE_2_LSB-1:BYTE_1_LSB]))
    else $error("Capture location middle byte read wrong.");

  // The detector applies magnification, so a magnified location reads through unaltered.
  pos_zoom_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R10
    (cfg_rd_in && cfg_addr_in == ADDR_POS_0 && sysref_status_magnify_in) |=>
      cfg_rdata_out == $past(sysref_capture_location_in[BYTE_1_LSB-1:0]))
    else $error("Magnified capture location low byte read wrong.");

  // Without magnification the low capture byte reads through as well.
  pos_low_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R01
    (cfg_rd_in && cfg_addr_in == ADDR_POS_0 && !sysref_status_magnify_in) |=>
      cfg_rdata_out == $past(sysref_capture_location_in[BYTE_1_LSB-1:0]))
    else $error("Capture location low byte read wrong.");

  // Reset loads the input A word with the default code.
  fsa_reset_a: assert property (@(posedge clk_sys_in) // R03
    srst_in |=> input_a_fullscale_word_out == FS_RESET)
    else $error("Input A word not at reset value.");

  // Reset loads the input B word with the same default code.
  fsb_reset_a: assert property (@(posedge clk_sys_in) // R05
    srst_in |=> input_b_fullscale_word_out == FS_RESET)
    else $error("Input B word not at reset value.");

  // Reset clears the bypass, timestamp and pre-emphasis outputs.
  ctrl_reset_a: assert property (@(posedge clk_sys_in) // R06 R07 R08 R09
    srst_in |=> !reference_bypass_bit_out && !timestamp_receiver_enable_out &&
      !timestamp_low_swing_mode_out && lane_pre_emphasis_out == BYTE_RESET[PE_W-1:0])
    else $error("Control outputs not cleared by reset.");

  // The high byte of the input A word takes its own write.
  fsa_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R03
    wr_fsa1 |=>
      input_a_fullscale_word_out[FS_W-1:BYTE_1_LSB] == $past(cfg_wdata_in))
    else $error("Input A high byte write lost.");

  // The low byte of the input A word takes its own write.
  fsa_low_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R03
    wr_fsa0 |=>
      input_a_fullscale_word_out[BYTE_1_LSB-1:0] == $past(cfg_wdata_in))
    else $error("Input A low byte write lost.");

  // The high byte of the input B word takes its own write.
  fsb_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R05
    wr_fsb1 |=>
      input_b_fullscale_word_out[FS_W-1:BYTE_1_LSB] == $past(cfg_wdata_in))
    else $error("Input B high byte write lost.");

  // The low byte of the input B word takes its own write.
  fsb_low_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R05
    wr_fsb0 |=>
      input_b_fullscale_word_out[BYTE_1_LSB-1:0] == $past(cfg_wdata_in))
    else $error("Input B low byte write lost.");

  // Input B keeps its word while only other registers are written.
  fsb_indep_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R05
    (!wr_fsb0 && !wr_fsb1) |=>
      $stable(input_b_fullscale_word_out))
    else $error("Input B word changed without its write.");

  // The bypass bit follows its written value.
  byp_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R06
    wr_byp |=>
      reference_bypass_bit_out == $past(cfg_wdata_in[BYP_BIT]))
    else $error("Reference bypass bit not written.");

  // The receiver enable follows its written value.
  ts_enable_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R07
    wr_ts |=>
      timestamp_receiver_enable_out == $past(cfg_wdata_in[TS_EN_BIT]))
    else $error("Timestamp receiver enable not written.");

  // The low-swing mode holds while its register is left alone.
  ts_swing_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R08
    (!wr_ts ##1 !wr_ts) |=>
      $stable(timestamp_low_swing_mode_out))
    else $error("Low-swing mode changed without a write.");

  // The low-swing mode follows its written value.
  ts_mode_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R08
    wr_ts |=>
      timestamp_low_swing_mode_out == $past(cfg_wdata_in[TS_LV_BIT]))
    else $error("Low-swing mode not written.");

  // The global pre-emphasis field follows its written value.
  pe_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R09
    wr_pe |=>
      lane_pre_emphasis_out == $past(cfg_wdata_in[PE_W-1:0]))
    else $error("Pre-emphasis not written.");

  // A write to the low capture byte leaves the input A word, pre-emphasis and timestamp registers unchanged.
  pos_nowrite_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R11
    (cfg_wr_in && cfg_addr_in == ADDR_POS_0) |=>
      $stable(input_a_fullscale_word_out) && $stable(pe_q) && $stable(ts_q))
    else $error("Write to capture location disturbed registers.");

  // A write to the high capture byte leaves both full-scale words and the bypass register unchanged.
  pos_top_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R11
    (cfg_wr_in && cfg_addr_in == ADDR_POS_2) |=>
      $stable(fsa_q) && $stable(fsb_q) && $stable(byp_q))
    else $error("Write to capture high byte disturbed registers.");

endmodule

/* test/tb.sv */
// Purpose: Self-checking bench for the converter register bank.
// Assumes: Byte port with one-cycle strobes; read data lands one cycle after the strobe.
// Notes:   Expected values come from a byte mirror that the bench keeps itself.
`timescale 1ns/1ns
module tb;
  import ascr_pkg::*;
  logic        clk_sys_in, srst_in, wr, rd, mag, byp, ts_en, ts_lv;
  logic [11:0] addr;
  logic [7:0]  wd, rdata;
  logic [23:0] cap;
  logic [15:0] fsa, fsb;
  logic [3:0]  pe;
  int          num_errors, num_checks;
  logic [7:0]  mem [logic [11:0]];
  logic [11:0] rw_a [7] = '{ADDR_FSA_0, ADDR_FSA_1, ADDR_FSB_0, ADDR_FSB_1,
                            ADDR_BYP, ADDR_TS, ADDR_PE};
  ascr_regs ascr_regs_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .cfg_addr_in(addr),
    .cfg_wdata_in(wd), .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_rdata_out(rdata),
    .sysref_capture_location_in(cap), .sysref_status_magnify_in(mag),
    .input_a_fullscale_word_out(fsa), .input_b_fullscale_word_out(fsb),
    .reference_bypass_bit_out(byp), .timestamp_receiver_enable_out(ts_en),
    .timestamp_low_swing_mode_out(ts_lv), .lane_pre_emphasis_out(pe));
  // Free-running 25 MHz clock.
  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // Compares one result and counts it.
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read value expected from the mirror, the live capture bytes, or zero elsewhere.
  function automatic logic [7:0] exp_rd(input logic [11:0] a);
    if (mem.exists(a)) return mem[a];
    case (a)
      ADDR_POS_0: return cap[7:0];
      ADDR_POS_1: return cap[15:8];
      ADDR_POS_2: return cap[23:16];
      default:    return 8'h00;
    endcase
  endfunction
  // One write or read strobe; a read is compared where the data has landed.
  task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (w && mem.exists(a)) mem[a] = d;
    if (!w) chk("rdata", exp_rd(a), rdata);
  endtask
  // Control outputs against the mirror.
  task outs;
    chk("fsa", {mem[ADDR_FSA_1], mem[ADDR_FSA_0]}, fsa);
    chk("fsb", {mem[ADDR_FSB_1], mem[ADDR_FSB_0]}, fsb);
    chk("byp", mem[ADDR_BYP][BYP_BIT], byp);
    chk("ts_en", mem[ADDR_TS][TS_EN_BIT], ts_en);
    chk("ts_lv", mem[ADDR_TS][TS_LV_BIT], ts_lv);
    chk("pe", mem[ADDR_PE][3:0], pe);
    foreach (rw_a[i]) acc(1'b0, rw_a[i], 8'h00);
  endtask
  // Holds reset for ten cycles and reloads the mirror with reset values.
  task rst;
    foreach (rw_a[i]) mem[rw_a[i]] = BYTE_RESET;
    mem[ADDR_FSA_1] = FS_RESET[15:8];
    mem[ADDR_FSB_1] = FS_RESET[15:8];
    srst_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    #1;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence: reset, corners, random traffic, capture and unmapped places, reset again.
  initial
  begin
    {srst_in, wr, rd, mag, addr, wd, cap} = '0;
    void'($urandom(32'hE83FACD6));
    rst();
    outs();
    $display("test reset done");
    foreach (rw_a[i]) acc(1'b1, rw_a[i], 8'hFF);
    outs();
    foreach (rw_a[i]) acc(1'b1, rw_a[i], 8'h00);
    outs();
    $display("test corners done");
    repeat (60) acc(1'($urandom_range(1, 0)), rw_a[$urandom_range(6, 0)], 8'($urandom));
    outs();
    $display("test random done");
    repeat (8)
    begin
      cap <= 24'($urandom);
      mag <= 1'($urandom);
      acc(1'b1, ADDR_POS_0 + 12'($urandom_range(2, 0)), 8'($urandom));
      for (int k = 0; k < 3; k++) acc(1'b0, ADDR_POS_0 + 12'(k), 8'h00);
    end
    $display("test capture done");
    acc(1'b1, 12'h03C, 8'h5A);
    acc(1'b0, 12'h03C, 8'h00);
    acc(1'b0, 12'h049, 8'h00);
    outs();
    $display("test unmapped done");
    rst();
    outs();
    $display("test second reset done");
    complete_run();
  end
endmodule
